// File: inc/usb_host_consts.svh
`ifndef USB_HOST_CONSTS_SVH
`define USB_HOST_CONSTS_SVH
// Behaviour
// - Status word 8008h hands an eight-byte setup command to the engine.
// - Target address is seven bits, zero after reset, 1 to 127 after enumeration.
// - Token d0h sends SETUP to endpoint zero, then the descriptor's data packet.
// - After the packets, handshake goes to descriptor PID in the same cycle the transfer-done flag sets.
// - Status word c040h gives ownership, DATA1 toggle and a 64-byte count.
// - Token 90h sends IN, receives data, writes back status, sets transfer-done.
// - Status word 8000h gives ownership with DATA0 and zero byte count.
// - Token 01h sends OUT plus zero-length packet, records handshake, sets done; the code issues 01h as PID 0 to endpoint 1.
// - Retry-disable bit 6 clear: NAKed transfers are retried without limit.
// - Retries disabled: ACK, NAK or STALL returned in PID; errors return 0fh.
// - SE0 longer than 2.5 us is a detach and sets status bit 0.
// - Ownership bit zero: engine ignores the descriptor and does not start.
// - On completion the byte count becomes the bytes actually moved.
// - Flags are set by hardware only; writing one clears, zero has no effect.

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_EP0_CTRL 9'h000
`define OFS_TARGET_ADDR 9'h004
`define OFS_TOKEN 9'h008
`define OFS_IRQ_STATUS 9'h00c
`define OFS_DESC_STATUS 9'h010
`define OFS_DESC_PTR 9'h014
`define OFS_OTG_CTRL 9'h018
`define OFS_OTG_IRQ 9'h01c
`define OFS_CONFIG_TWO 9'h020
`define BUF_ADR_BIT 8

// ****************************************
// Field positions
// ****************************************
`define EP0_HANDSHAKE_BIT 0
`define EP0_TRANSMIT_BIT 2
`define EP0_SETUP_SUPPRESS_BIT 3
`define EP0_RECEIVE_BIT 4
`define EP0_RETRY_DIS_BIT 6
`define EP0_LOW_SPEED_BIT 7
`define IRQ_DETACH_BIT 0
`define IRQ_DONE_BIT 3
`define IRQ_ATTACH_BIT 6
`define OTG_SESS_END_BIT 2
`define OTG_SESS_VALID_BIT 3
`define OTGC_DPLUS_BIT 7
`define OTGC_DMINUS_BIT 6
`define OTGC_VBUS_ON_BIT 3
`define OTGC_DISCHARGE_BIT 0
`define CFG2_VBUS_PULSE_BIT 4
`define DESC_OWN_BIT 15
`define DESC_DTS_BIT 14
`define DESC_PID_LSB 16

// ****************************************
// Packet identifiers and reset values
// ****************************************
`define PID_OUT 4'h1
`define PID_ACK 4'h2
`define PID_DATA0 4'h3
`define PID_IN 4'h9
`define PID_NAK 4'ha
`define PID_DATA1 4'hb
`define PID_SETUP 4'hd
`define PID_STALL 4'he
`define PID_ERROR 4'hf
`define RST_EP0_CTRL 8'h00
`define RST_TARGET_ADDR 8'h00

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 100
`define DETACH_SE0_NS 2500
`define DETACH_CYCLES ((`DETACH_SE0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: inc/usb_host_pkg.sv
package usb_host_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_TOKEN = 7'b0000010,
		ST_TX = 7'b0000100,
		ST_HS = 7'b0001000,
		ST_RX = 7'b0010000,
		ST_DONE = 7'b0100000,
		ST_ACK = 7'b1000000
	} xfer_state_e;
endpackage

// File: verilog/usb_host_xfer.sv
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "usb_host_consts.svh"
module usb_host_xfer #(
	parameter int BUF_DEPTH = 64,
	parameter int DETACH_CYCLES = `DETACH_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic tok_valid_o,
	output logic [3:0] tok_pid_o,
	output logic [6:0] tok_addr_o,
	output logic [3:0] tok_ep_o,
	output logic tok_ls_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	output logic tx_empty_o,
	output logic [3:0] tx_dpid_o,
	input wire logic tx_ready_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_end_i,
	input wire logic rx_err_i,
	input wire logic hs_valid_i,
	input wire logic [3:0] hs_pid_i,
	input wire logic hs_err_i,
	output logic ack_send_o,
	input wire logic se0_i,
	input wire logic sess_end_i,
	input wire logic sess_valid_i,
	output logic dplus_pullup_en_o,
	output logic dminus_pullup_en_o,
	output logic vbus_supply_enable_o,
	output logic vbus_discharge_en_o,
	output logic vbus_pulse_en_o
);
	import usb_host_pkg::*;

	localparam int AW = $clog2(BUF_DEPTH);

	// ****************************************
	// Bus slave
	// ****************************************
	logic ack_q;
	logic [31:0] rdat_q;
	logic [7:0] ep0_ctrl_q;
	logic [7:0] addr_q;
	logic [7:0] token_q;
	logic [7:0] irq_q;
	logic [7:0] otg_irq_q;
	logic [7:0] otg_ctrl_q;
	logic [7:0] cfg2_q;
	logic desc_own_q;
	logic desc_dts_q;
	logic [9:0] desc_bc_q;
	logic [3:0] desc_pid_q;
	logic [AW-1:0] desc_ptr_q;
	logic [7:0] buf_q [BUF_DEPTH];
	xfer_state_e st_q;
	logic [9:0] idx_q;
	logic [3:0] result_q;
	logic [9:0] se0_cnt_q;
	logic detached_q;
	logic sess_end_prev_q;
	logic sess_valid_prev_q;
	logic wr;
	logic wr_lo;
	logic tok_wr;
	logic tok_start;
	logic [AW-1:0] buf_idx;
	logic [AW-1:0] tx_next_idx;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
	assign wr_lo = wr && wb_sel_i[0];
	assign tok_wr = wr_lo && wb_adr_i == `OFS_TOKEN;
	// Tokens written mid-transfer are dropped; software must wait for done
	assign tok_start = tok_wr && st_q == ST_IDLE && desc_own_q;
	assign buf_idx = desc_ptr_q + idx_q[AW-1:0];
	assign tx_next_idx = buf_idx + AW'(1);

	// Write lands at the edge where the master sees ack
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else if (ce_i)
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdat_q <= 32'h0;
		else if (ce_i && wb_cyc_i && wb_stb_i && !ack_q)
		begin
			rdat_q <= 32'h0;
			if (wb_adr_i[`BUF_ADR_BIT])
				rdat_q[7:0] <= buf_q[wb_adr_i[AW+1:2]];
			else
				case (wb_adr_i)
					`OFS_EP0_CTRL: rdat_q[7:0] <= ep0_ctrl_q;
					`OFS_TARGET_ADDR: rdat_q[7:0] <= addr_q;
					`OFS_TOKEN: rdat_q[7:0] <= token_q;
					`OFS_IRQ_STATUS: rdat_q[7:0] <= irq_q;
					`OFS_DESC_STATUS: rdat_q[19:0] <= {desc_pid_q, desc_own_q, desc_dts_q, 4'h0, desc_bc_q};
					`OFS_DESC_PTR: rdat_q[AW-1:0] <= desc_ptr_q;
					`OFS_OTG_CTRL: rdat_q[7:0] <= otg_ctrl_q;
					`OFS_OTG_IRQ: rdat_q[7:0] <= otg_irq_q;
					`OFS_CONFIG_TWO: rdat_q[7:0] <= cfg2_q;
					default: rdat_q <= 32'h0;
				endcase
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ****************************************
	// Control registers
	// ****************************************
	// Speed and pull-ups are taken as static while a transfer runs
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ep0_ctrl_q <= `RST_EP0_CTRL;
			addr_q <= `RST_TARGET_ADDR;
			otg_ctrl_q <= 8'h00;
			cfg2_q <= 8'h00;
			token_q <= 8'h00;
		end
		else if (ce_i && wr_lo)
		begin
			case (wb_adr_i)
				`OFS_EP0_CTRL: ep0_ctrl_q <= wb_dat_i[7:0];
				`OFS_TARGET_ADDR: addr_q <= wb_dat_i[7:0];
				`OFS_OTG_CTRL: otg_ctrl_q <= wb_dat_i[7:0];
				`OFS_CONFIG_TWO: cfg2_q <= wb_dat_i[7:0];
				`OFS_TOKEN: if (tok_start) token_q <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dplus_pullup_en_o <= 1'b0;
			dminus_pullup_en_o <= 1'b0;
			vbus_supply_enable_o <= 1'b0;
			vbus_discharge_en_o <= 1'b0;
			vbus_pulse_en_o <= 1'b0;
			tok_addr_o <= 7'h0;
			tok_ls_o <= 1'b0;
		end
		else if (ce_i)
		begin
			dplus_pullup_en_o <= otg_ctrl_q[`OTGC_DPLUS_BIT];
			dminus_pullup_en_o <= otg_ctrl_q[`OTGC_DMINUS_BIT];
			vbus_supply_enable_o <= otg_ctrl_q[`OTGC_VBUS_ON_BIT];
			vbus_discharge_en_o <= otg_ctrl_q[`OTGC_DISCHARGE_BIT];
			vbus_pulse_en_o <= cfg2_q[`CFG2_VBUS_PULSE_BIT];
			tok_addr_o <= addr_q[6:0];
			tok_ls_o <= ep0_ctrl_q[`EP0_LOW_SPEED_BIT];
		end
	end

	// ****************************************
	// Descriptor and packet buffer
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			desc_own_q <= 1'b0;
			desc_dts_q <= 1'b0;
			desc_bc_q <= 10'h0;
			desc_pid_q <= 4'h0;
			desc_ptr_q <= '0;
		end
		else if (ce_i)
		begin
			if (st_q == ST_DONE)
			begin
				desc_own_q <= 1'b0;
				desc_pid_q <= result_q;
				desc_bc_q <= idx_q;
			end
			else if (wr && wb_adr_i == `OFS_DESC_STATUS)
			begin
				// 8008h, c040h and 8000h all arrive through this path
				if (wb_sel_i[0])
					desc_bc_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
				begin
					desc_bc_q[9:8] <= wb_dat_i[9:8];
					desc_dts_q <= wb_dat_i[`DESC_DTS_BIT];
					desc_own_q <= wb_dat_i[`DESC_OWN_BIT];
				end
			end
			else if (wr_lo && wb_adr_i == `OFS_DESC_PTR)
				desc_ptr_q <= wb_dat_i[AW-1:0];
		end
	end

	// Received bytes win over a bus write to the same cell
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			if (st_q == ST_RX && rx_valid_i && idx_q < desc_bc_q)
				buf_q[buf_idx] <= rx_data_i;
			else if (wr_lo && wb_adr_i[`BUF_ADR_BIT])
				buf_q[wb_adr_i[AW+1:2]] <= wb_dat_i[7:0];
		end
	end

	// ****************************************
	// Transaction engine
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q <= ST_IDLE;
			idx_q <= 10'h0;
			result_q <= 4'h0;
			tok_valid_o <= 1'b0;
			tok_pid_o <= 4'h0;
			tok_ep_o <= 4'h0;
			tx_valid_o <= 1'b0;
			tx_data_o <= 8'h0;
			tx_last_o <= 1'b0;
			tx_empty_o <= 1'b0;
			tx_dpid_o <= `PID_DATA0;
			ack_send_o <= 1'b0;
		end
		else if (ce_i)
		begin
			ack_send_o <= 1'b0;
			case (st_q)
				ST_IDLE:
					if (tok_start)
					begin
						tok_valid_o <= 1'b1;
						tok_pid_o <= wb_dat_i[7:4];
						tok_ep_o <= wb_dat_i[3:0];
						tx_dpid_o <= desc_dts_q ? `PID_DATA1 : `PID_DATA0;
						idx_q <= 10'h0;
						st_q <= ST_TOKEN;
					end
				ST_TOKEN:
					if (tx_ready_i)
					begin
						tok_valid_o <= 1'b0;
						if (tok_pid_o == `PID_IN)
							st_q <= ST_RX;
						else
						begin
							// SETUP and OUT carry a packet; count zero sends an empty one
							tx_valid_o <= 1'b1;
							tx_data_o <= buf_q[buf_idx];
							tx_last_o <= (desc_bc_q <= 10'h1);
							tx_empty_o <= desc_bc_q == 10'h0;
							st_q <= ST_TX;
						end
					end
				ST_TX:
					if (tx_ready_i)
					begin
						if (!tx_empty_o)
							idx_q <= idx_q + 10'h1;
						if (tx_last_o)
						begin
							tx_valid_o <= 1'b0;
							tx_last_o <= 1'b0;
							tx_empty_o <= 1'b0;
							st_q <= ST_HS;
						end
						else
						begin
							tx_data_o <= buf_q[tx_next_idx];
							tx_last_o <= idx_q + 10'h2 >= desc_bc_q;
						end
					end
				ST_HS, ST_RX:
					if (hs_valid_i && hs_pid_i == `PID_NAK && !ep0_ctrl_q[`EP0_RETRY_DIS_BIT])
					begin
						tok_valid_o <= 1'b1;
						idx_q <= 10'h0;
						st_q <= ST_TOKEN;
					end
					else if (hs_valid_i)
					begin
						result_q <= hs_pid_i;
						st_q <= ST_DONE;
					end
					else if (hs_err_i || (st_q == ST_RX && rx_err_i))
					begin
						result_q <= `PID_ERROR;
						st_q <= ST_DONE;
					end
					else if (st_q == ST_RX && rx_valid_i && idx_q < desc_bc_q)
						idx_q <= idx_q + 10'h1;
					else if (st_q == ST_RX && rx_end_i)
					begin
						ack_send_o <= 1'b1;
						result_q <= tx_dpid_o;
						st_q <= ST_ACK;
					end
				ST_ACK:
					st_q <= ST_DONE;
				ST_DONE:
					st_q <= ST_IDLE;
				default:
					st_q <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// Line watch and status flags
	// ****************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			se0_cnt_q <= 10'h0;
			detached_q <= 1'b1;
			sess_end_prev_q <= 1'b0;
			sess_valid_prev_q <= 1'b0;
		end
		else if (ce_i)
		begin
			sess_end_prev_q <= sess_end_i;
			sess_valid_prev_q <= sess_valid_i;
			if (!se0_i)
			begin
				se0_cnt_q <= 10'h0;
				detached_q <= 1'b0;
			end
			else if (se0_cnt_q < 10'(DETACH_CYCLES))
				se0_cnt_q <= se0_cnt_q + 10'h1;
			else
				detached_q <= 1'b1;
		end
	end

	// Hardware sets beat a same-cycle write-one clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_q <= 8'h00;
			otg_irq_q <= 8'h00;
		end
		else if (ce_i)
		begin
			irq_q <= (irq_q & ~((wr_lo && wb_adr_i == `OFS_IRQ_STATUS) ? wb_dat_i[7:0] : 8'h00))
				| (8'((st_q == ST_DONE)) << `IRQ_DONE_BIT)
				| (8'(se0_i && se0_cnt_q == 10'(DETACH_CYCLES) && !detached_q) << `IRQ_DETACH_BIT)
				| (8'(!se0_i && detached_q) << `IRQ_ATTACH_BIT);
			otg_irq_q <= (otg_irq_q & ~((wr_lo && wb_adr_i == `OFS_OTG_IRQ) ? wb_dat_i[7:0] : 8'h00))
				| (8'(sess_end_i && !sess_end_prev_q) << `OTG_SESS_END_BIT)
				| (8'(sess_valid_i && !sess_valid_prev_q) << `OTG_SESS_VALID_BIT);
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i iff ce_i);
	endclocking
	default disable iff (rst_i);

	sequence s_done;
		st_q == ST_DONE;
	endsequence

	sequence s_written_back;
		!desc_own_q && irq_q[`IRQ_DONE_BIT];
	endsequence

	property p_setup_token;
		tok_start && wb_dat_i[7:0] == 8'hd0 |=> tok_valid_o && tok_pid_o == `PID_SETUP && tok_ep_o == 4'h0;
	endproperty
	a_setup_token: assert property (p_setup_token) else $error("setup token not issued");

	property p_done_writeback;
		s_done |=> s_written_back ##0 desc_pid_q == $past(result_q);
	endproperty
	a_done_writeback: assert property (p_done_writeback) else $error("descriptor not written back");

	property p_in_receive;
		st_q == ST_TOKEN && tx_ready_i && tok_pid_o == `PID_IN |=> st_q == ST_RX && !tx_valid_o;
	endproperty
	a_in_receive: assert property (p_in_receive) else $error("IN token did not enter receive");

	property p_out_zlp;
		st_q == ST_TOKEN && tx_ready_i && tok_pid_o == `PID_OUT && desc_bc_q == 10'h0
			|=> tx_valid_o && tx_empty_o && tx_last_o;
	endproperty
	a_out_zlp: assert property (p_out_zlp) else $error("zero-length packet missing");

	property p_nak_retry;
		st_q == ST_HS && hs_valid_i && hs_pid_i == `PID_NAK && !ep0_ctrl_q[`EP0_RETRY_DIS_BIT]
			|=> tok_valid_o && st_q == ST_TOKEN ##1 !irq_q[`IRQ_DONE_BIT] || $past(irq_q[`IRQ_DONE_BIT]);
	endproperty
	a_nak_retry: assert property (p_nak_retry) else $error("NAK not retried");

	property p_no_retry;
		st_q == ST_HS && hs_valid_i && ep0_ctrl_q[`EP0_RETRY_DIS_BIT] |=> s_done ##1 desc_pid_q == $past(hs_pid_i, 2);
	endproperty
	a_no_retry: assert property (p_no_retry) else $error("handshake not returned");

	property p_detach;
		se0_i && se0_cnt_q == 10'(DETACH_CYCLES) && !detached_q |=> irq_q[`IRQ_DETACH_BIT];
	endproperty
	a_detach: assert property (p_detach) else $error("detach flag not set");

	property p_not_owned;
		tok_wr && st_q == ST_IDLE && !desc_own_q |=> st_q == ST_IDLE && !tok_valid_o;
	endproperty
	a_not_owned: assert property (p_not_owned) else $error("started without ownership");

	property p_byte_count;
		s_done |=> desc_bc_q == $past(idx_q);
	endproperty
	a_byte_count: assert property (p_byte_count) else $error("byte count not updated");

	property p_set_wins;
		s_done |=> irq_q[`IRQ_DONE_BIT] [*1] ##1 irq_q[`IRQ_DONE_BIT] || $past(wr_lo);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("done flag lost to clear");

	property p_addr_reset;
		$past(rst_i) |-> tok_addr_o == 7'h0;
	endproperty
	a_addr_reset: assert property (p_addr_reset) else $error("address not zero after reset");
endmodule

// File: tb/usb_peripheral_model.sv
`timescale 1ns/1ps
`include "usb_host_consts.svh"
module usb_peripheral_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic slow_i,
	input wire logic [3:0] reply_i,
	input wire logic [3:0] naks_i,
	input wire logic [7:0] in_len_i,
	input wire logic tok_valid_i,
	input wire logic [3:0] tok_pid_i,
	input wire logic tx_valid_i,
	input wire logic tx_last_i,
	output logic tx_ready_o,
	output logic rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic rx_end_o,
	output logic hs_valid_o,
	output logic [3:0] hs_pid_o,
	output logic hs_err_o
);
	logic wait_q, resp_q, data_q, give;
	logic [3:0] nak_q;
	logic [7:0] idx_q;
	assign give = reply_i == `PID_ACK && nak_q >= naks_i;
	always_ff @(posedge clk_i)
	begin
		rx_valid_o <= 1'b0;
		rx_end_o <= 1'b0;
		hs_valid_o <= 1'b0;
		hs_err_o <= 1'b0;
		// Idle lines keep moving so stale data never looks valid
		rx_data_o <= ~rx_data_o;
		hs_pid_o <= ~hs_pid_o;
		tx_ready_o <= !slow_i || !tx_ready_o;
		if (rst_i)
			{wait_q, resp_q, data_q, nak_q, idx_q, tx_ready_o, rx_data_o, hs_pid_o} <= '0;
		else if (tok_valid_i && tx_ready_o)
		begin
			data_q <= tok_pid_i == `PID_IN && give;
			resp_q <= tok_pid_i == `PID_IN && !give;
			wait_q <= tok_pid_i != `PID_IN;
			idx_q <= '0;
		end
		else if (wait_q && tx_valid_i && tx_ready_o && tx_last_i)
		begin
			wait_q <= 1'b0;
			resp_q <= 1'b1;
		end
		else if (resp_q)
		begin
			resp_q <= 1'b0;
			nak_q <= nak_q < naks_i ? nak_q + 4'h1 : 4'h0;
			hs_valid_o <= nak_q < naks_i || reply_i != `PID_ERROR;
			hs_err_o <= nak_q >= naks_i && reply_i == `PID_ERROR;
			hs_pid_o <= nak_q < naks_i ? `PID_NAK : reply_i;
		end
		else if (data_q)
		begin
			rx_end_o <= idx_q == in_len_i;
			data_q <= idx_q != in_len_i;
			rx_valid_o <= idx_q != in_len_i;
			rx_data_o <= idx_q ^ 8'h5a;
			idx_q <= idx_q + 8'h1;
		end
	end
endmodule

// File: tb/usb_otg_host_transfer_srp_test.sv
`timescale 1ns/1ps
`include "usb_host_consts.svh"
module usb_otg_host_transfer_srp_test;
	import usb_host_pkg::*;
	logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, tx_ready_i, rx_valid_i, rx_end_i, rx_err_i;
	logic hs_valid_i, hs_err_i, se0_i, sess_end_i, sess_valid_i, slow, wb_ack_o, tok_valid_o, tok_ls_o;
	logic tx_valid_o, tx_last_o, tx_empty_o, ack_send_o, dplus_pullup_en_o, dminus_pullup_en_o;
	logic vbus_supply_enable_o, vbus_discharge_en_o, vbus_pulse_en_o;
	logic [8:0] wb_adr_i;
	logic [3:0] wb_sel_i, tok_pid_o, tok_ep_o, tx_dpid_o, hs_pid_i, reply, naks, last_dpid;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [6:0] tok_addr_o;
	logic [7:0] tx_data_o, rx_data_i, in_len;
	logic [7:0] txq[$];
	logic [14:0] last_tok;
	int mismatches, total_checks, toks, empties, acks, t0;

	usb_host_xfer u_usb_host_xfer (
		.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .tok_valid_o, .tok_pid_o, .tok_addr_o, .tok_ep_o, .tok_ls_o, .tx_valid_o, .tx_data_o,
		.tx_last_o, .tx_empty_o, .tx_dpid_o, .tx_ready_i, .rx_valid_i, .rx_data_i, .rx_end_i, .rx_err_i,
		.hs_valid_i, .hs_pid_i, .hs_err_i, .ack_send_o, .se0_i, .sess_end_i, .sess_valid_i,
		.dplus_pullup_en_o, .dminus_pullup_en_o, .vbus_supply_enable_o, .vbus_discharge_en_o, .vbus_pulse_en_o
	);
	usb_peripheral_model u_usb_peripheral_model (
		.clk_i, .rst_i, .slow_i(slow), .reply_i(reply), .naks_i(naks), .in_len_i(in_len),
		.tok_valid_i(tok_valid_o), .tok_pid_i(tok_pid_o), .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o),
		.tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_end_o(rx_end_i),
		.hs_valid_o(hs_valid_i), .hs_pid_o(hs_pid_i), .hs_err_o(hs_err_i)
	);

	always #50 clk_i = ~clk_i;

	// ****************************************
	// Link monitor
	// ****************************************
	always @(posedge clk_i)
	begin
		if (tok_valid_o && tx_ready_i)
		begin
			toks++;
			last_tok = {tok_pid_o, tok_ep_o, tok_addr_o};
		end
		if (tx_valid_o && tx_ready_i && !tx_empty_o)
			txq.push_back(tx_data_o);
		if (tx_valid_o && tx_ready_i)
			last_dpid = tx_dpid_o;
		if (tx_valid_o && tx_ready_i && tx_empty_o)
			empties++;
		if (ack_send_o)
			acks++;
	end

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic we, input logic [8:0] adr, input logic [31:0] wd, output logic [31:0] rd_d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= wd;
		// Only the watchdog ends a wait for ack
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1);
		rd_d = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [8:0] adr, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'b1, adr, wd, d);
	endtask

	task automatic rd(input logic [8:0] adr, input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] d;
		bus(1'b0, adr, '0, d);
		chk(d & mask, exp);
	endtask

	task automatic xact(input logic [31:0] stat, input logic [31:0] tok, input logic [31:0] exp);
		logic [31:0] d;
		d = '0;
		wr(`OFS_DESC_STATUS, stat);
		wr(`OFS_TOKEN, tok);
		// Polled: retry rounds have no fixed length
		while (d[`IRQ_DONE_BIT] !== 1'b1)
			bus(1'b0, `OFS_IRQ_STATUS, '0, d);
		rd(`OFS_DESC_STATUS, exp, 32'h000f_83ff);
		wr(`OFS_IRQ_STATUS, '0);
		rd(`OFS_IRQ_STATUS, 32'h8, 32'h8);
		wr(`OFS_IRQ_STATUS, 32'h8);
		rd(`OFS_IRQ_STATUS, '0, 32'h8);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		summarize();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		{clk_i, ce_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, rx_err_i, se0_i, sess_end_i, sess_valid_i} = 10'h180;
		{wb_adr_i, wb_dat_i, wb_sel_i, slow, naks, in_len, reply} = {9'h0, 32'h0, 4'hf, 1'b0, 4'h0, 8'h5, `PID_ACK};
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`OFS_EP0_CTRL, `RST_EP0_CTRL, 32'hff);
		rd(`OFS_TARGET_ADDR, '0, 32'h7f);
		rd(9'h0fc, '0, 32'hffff_ffff);
		$display("test reset done");
		wr(`OFS_EP0_CTRL, 32'h0d);
		wr(`OFS_TARGET_ADDR, 32'h7f);
		for (int i = 0; i < 8; i++)
			wr(9'h100 + 9'(4 * i), 32'(i * 17));
		wr(`OFS_DESC_PTR, '0);
		xact(32'h8008, 32'hd0, 32'h0002_0008);
		chk(32'(last_tok), 32'({`PID_SETUP, 4'h0, 7'h7f}));
		chk(32'(txq.size()), 32'd8);
		foreach (txq[i])
			chk(32'(txq[i]), 32'(i * 17));
		chk(32'(last_dpid), 32'(`PID_DATA0));
		$display("test setup done");
		wr(`OFS_DESC_PTR, 32'h10);
		xact(32'hc040, 32'h90, 32'h000b_0005);
		chk(32'(acks), 32'd1);
		for (int i = 0; i < 5; i++)
			rd(9'h140 + 9'(4 * i), 32'(i ^ 8'h5a), 32'hff);
		$display("test in done");
		t0 = empties;
		xact(32'h8000, 32'h01, 32'h0002_0000);
		chk(32'(empties - t0), 32'd1);
		chk(32'(last_dpid), 32'(`PID_DATA0));
		$display("test status done");
		wr(`OFS_EP0_CTRL, 32'h1d);
		slow <= 1'b1;
		naks <= 4'h3;
		t0 = toks;
		xact(32'h8000, 32'h01, 32'h0002_0000);
		chk(32'(toks - t0), 32'd4);
		slow <= 1'b0;
		naks <= 4'h0;
		$display("test retry done");
		wr(`OFS_EP0_CTRL, 32'h5d);
		reply <= `PID_NAK;
		xact(32'h8000, 32'h01, 32'h000a_0000);
		reply <= `PID_STALL;
		xact(32'h8000, 32'h01, 32'h000e_0000);
		reply <= `PID_ERROR;
		xact(32'h8000, 32'h01, 32'h000f_0000);
		reply <= `PID_ACK;
		$display("test no retry done");
		t0 = toks;
		wr(`OFS_DESC_STATUS, '0);
		wr(`OFS_TOKEN, 32'h01);
		repeat (40) @(posedge clk_i);
		chk(32'(toks - t0), '0);
		rd(`OFS_IRQ_STATUS, '0, 32'h8);
		$display("test unowned done");
		se0_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		se0_i <= 1'b0;
		rd(`OFS_IRQ_STATUS, '0, 32'h1);
		se0_i <= 1'b1;
		repeat (30) @(posedge clk_i);
		se0_i <= 1'b0;
		rd(`OFS_IRQ_STATUS, 32'h1, 32'h1);
		// Clock enable low must freeze the SE0 counter
		wr(`OFS_IRQ_STATUS, 32'h1);
		ce_i <= 1'b0;
		se0_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		ce_i <= 1'b1;
		se0_i <= 1'b0;
		rd(`OFS_IRQ_STATUS, '0, 32'h1);
		$display("test detach done");
		wr(`OFS_OTG_CTRL, 32'hc9);
		wr(`OFS_CONFIG_TWO, 32'h10);
		repeat (2) @(posedge clk_i);
		chk(32'({dplus_pullup_en_o, dminus_pullup_en_o, vbus_supply_enable_o, vbus_discharge_en_o,
			vbus_pulse_en_o}), 32'h1f);
		wr(`OFS_OTG_CTRL, '0);
		repeat (2) @(posedge clk_i);
		chk(32'({dplus_pullup_en_o, dminus_pullup_en_o, vbus_supply_enable_o}), '0);
		sess_end_i <= 1'b1;
		sess_valid_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd(`OFS_OTG_IRQ, 32'hc, 32'hc);
		wr(`OFS_OTG_CTRL, 32'h88);
		repeat (2) @(posedge clk_i);
		chk(32'({dplus_pullup_en_o, vbus_supply_enable_o}), 32'h3);
		$display("test otg done");
		summarize();
	end
endmodule
